//--- core/scm_mode_ctrl.sv
// Mode control of a serial channel: UART or synchronous frame modes
//
// Behaviour
// - Frame mode field: 00 sync, 01 seven, 10 eight, 11 nine-bit UART.
// - UART clock from field: timer, baud generator, system clock, clock pin.
// - Sync mode ignores UART clock field, uses control register clock choice.
// - Nine-bit UART sends stored ninth bit as bit 8.
// - Handshake enable gates transmission with CTS in UART modes only, else CTS ignored.
// - Wake-up in nine-bit UART: receive interrupt only when ninth bit is 1.
// - Idle-run bit: channel halts (0) or runs (1) in idle power mode.
// - Duplex field: none, half receive, half transmit, full duplex.
// - Sync: duplex sets direction and FIFO; UART: FIFO arrangement only.
// - Transmit enable permits transmission in every transfer mode.
// - Sync gap field: none, or 1 to 64 serial clocks between transmissions.
// - Gap only in sync mode, clock output, double buffering on.
// - Write 10 then 01 clears both enables and resets the engines.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module scm_mode_ctrl (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic CTS_PIN,
  input wire logic CHIP_IDLE,
  input wire logic CR_CLK_PIN_SEL,
  input wire logic SCLK_OUT_MODE,
  input wire logic DBL_BUF_EN,
  input wire logic FIFO_EN,
  input wire logic SCLK_TICK,
  input wire logic TX_DONE,
  input wire logic RX_DONE,
  input wire logic RX_NINTH,
  output logic [1:0] FRAME_MODE,
  output logic [3:0] DATA_BITS,
  output logic [1:0] XFER_CLK_SEL,
  output logic TX_BIT8,
  output logic TX_ALLOW,
  output logic RX_ALLOW,
  output logic RX_IRQ_PULSE,
  output logic CH_RUN,
  output logic [1:0] FIFO_ARR,
  output logic ENGINE_RST,
  output logic IRQ
);
  import scm_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] mode0_r;
  logic [7:0] mode1_r;
  logic swrst_armed_r;
  logic swrst_fire;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_set;
  logic cts_s1_r, cts_s2_r, cts_s3_r, cts_r;
  logic gap_busy;
  logic gap_on;
  logic rx_evt_ok;
  logic [31:0] rdata_nxt;

  function automatic logic is_uart(input logic [1:0] sm);
    return sm != FM_SYNC;
  endfunction

  function automatic logic [3:0] width_of(input logic [1:0] sm);
    case (sm)
      FM_UART7: return 4'h7;
      FM_UART9: return 4'h9;
      default: return 4'h8;
    endcase
  endfunction

  wire logic wr_m0 = WR && ADDR == SCM_MODE0_ADDR;
  wire logic wr_m1 = WR && ADDR == SCM_MODE1_ADDR;
  wire logic wr_sw = WR && ADDR == SCM_SWRST_ADDR;
  wire logic [1:0] sm = mode0_r[M0_SM_HI:M0_SM_LO];
  wire logic [1:0] dpx = mode1_r[M1_DPX_HI:M1_DPX_LO];

  // ----------------------------------------------------------------
  // Software reset key
  // ----------------------------------------------------------------
  // Firing needs an armed key, so a lone 01 write does nothing
  assign swrst_fire = wr_sw && swrst_armed_r && WDATA[1:0] == SWRST_FIRE;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      swrst_armed_r <= 1'b0;
    end else if (wr_sw) begin
      swrst_armed_r <= (WDATA[1:0] == SWRST_ARM);
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      mode0_r <= SCM_MODE0_RST;
    end else if (wr_m0) begin
      mode0_r <= WDATA[7:0];
    end else if (swrst_fire) begin
      mode0_r[M0_RXE] <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      mode1_r <= SCM_MODE1_RST;
    end else if (wr_m1) begin
      mode1_r <= {WDATA[7:1], 1'b0};
    end else if (swrst_fire) begin
      mode1_r[M1_TXE] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // CTS synchroniser, change taken when stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      cts_s1_r <= 1'b0;
      cts_s2_r <= 1'b0;
      cts_s3_r <= 1'b0;
      cts_r <= 1'b0;
    end else begin
      cts_s1_r <= CTS_PIN;
      cts_s2_r <= cts_s1_r;
      cts_s3_r <= cts_s2_r;
      if (cts_s2_r == cts_s3_r) begin
        cts_r <= cts_s3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmission gap
  // ----------------------------------------------------------------
  assign gap_on = !is_uart(sm) && SCLK_OUT_MODE && DBL_BUF_EN;

  scm_gap_timer u_gap (
    .CLK(CLK),
    .RST_B(RST_B),
    .start(TX_DONE && gap_on),
    .code(mode1_r[M1_GAP_HI:M1_GAP_LO]),
    .sclk_tick(SCLK_TICK),
    .flush(swrst_fire || !gap_on),
    .busy(gap_busy)
  );

  // ----------------------------------------------------------------
  // Derived mode outputs
  // ----------------------------------------------------------------
  logic run_nxt;
  logic tx_dir_ok;
  logic rx_dir_ok;
  logic tx_nxt;

  always_comb begin
    run_nxt = !CHIP_IDLE || mode1_r[M1_IDLE];
    // Direction gating applies in sync mode only
    tx_dir_ok = is_uart(sm) || dpx == DPX_TX || dpx == DPX_FULL;
    rx_dir_ok = is_uart(sm) || dpx == DPX_RX || dpx == DPX_FULL;
    tx_nxt = mode1_r[M1_TXE] && tx_dir_ok && run_nxt && !gap_busy
             && !(is_uart(sm) && mode0_r[M0_HSK] && !cts_r);
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      FRAME_MODE <= FM_SYNC;
      DATA_BITS <= 4'h8;
      XFER_CLK_SEL <= CK_TIMER;
      TX_BIT8 <= 1'b0;
      TX_ALLOW <= 1'b0;
      RX_ALLOW <= 1'b0;
      CH_RUN <= 1'b0;
      FIFO_ARR <= DPX_NONE;
      ENGINE_RST <= 1'b0;
    end else begin
      FRAME_MODE <= sm;
      DATA_BITS <= width_of(sm);
      if (is_uart(sm)) begin
        XFER_CLK_SEL <= mode0_r[M0_SC_HI:M0_SC_LO];
      end else begin
        XFER_CLK_SEL <= CR_CLK_PIN_SEL ? CK_PIN : CK_BRG;
      end
      TX_BIT8 <= (sm == FM_UART9) && mode0_r[M0_TX9];
      TX_ALLOW <= tx_nxt && !swrst_fire;
      RX_ALLOW <= mode0_r[M0_RXE] && rx_dir_ok && run_nxt && !swrst_fire;
      CH_RUN <= run_nxt;
      FIFO_ARR <= (FIFO_EN || is_uart(sm)) ? dpx : DPX_NONE;
      ENGINE_RST <= swrst_fire;
    end
  end

  // ----------------------------------------------------------------
  // Receive event filter and interrupts
  // ----------------------------------------------------------------
  assign rx_evt_ok = RX_DONE && (!(sm == FM_UART9 && mode0_r[M0_WU]) || RX_NINTH);

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RX_IRQ_PULSE <= 1'b0;
    end else begin
      RX_IRQ_PULSE <= rx_evt_ok;
    end
  end

  assign irq_set = {swrst_fire, rx_evt_ok};

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((WR && ADDR == SCM_IRQ_CLR_ADDR) ? WDATA[IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      irq_en_r <= '0;
    end else if (WR && ADDR == SCM_IRQ_EN_ADDR) begin
      irq_en_r <= WDATA[IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((irq_stat_r | irq_set) & irq_en_r));
    end
  end

  // ----------------------------------------------------------------
  // Read port, upper bits zero, unmapped reads zero
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (ADDR)
      SCM_MODE0_ADDR: rdata_nxt[7:0] = mode0_r;
      SCM_MODE1_ADDR: rdata_nxt[7:0] = mode1_r;
      SCM_STAT_ADDR: rdata_nxt[3:0] = {gap_busy, cts_r, TX_ALLOW, RX_ALLOW};
      SCM_IRQ_STAT_ADDR: rdata_nxt[IRQ_W-1:0] = irq_stat_r;
      SCM_IRQ_EN_ADDR: rdata_nxt[IRQ_W-1:0] = irq_en_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      RDATA <= rdata_nxt;
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence key_pair_s;
    wr_sw && WDATA[1:0] == SWRST_ARM ##1 wr_sw && WDATA[1:0] == SWRST_FIRE;
  endsequence

  // Key writes with one idle bus cycle between them still fire
  sequence key_gap_s;
    wr_sw && WDATA[1:0] == SWRST_ARM ##1 !wr_sw ##1 wr_sw && WDATA[1:0] == SWRST_FIRE;
  endsequence

  swrst_clear_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (key_pair_s or key_gap_s) |=> !mode0_r[M0_RXE] && !mode1_r[M1_TXE] && ENGINE_RST && !TX_ALLOW)
    else $error("software reset did not clear enables");
  frame_width_a: assert property (@(posedge CLK) disable iff (!RST_B)
    $past(sm) == FM_UART7 |-> DATA_BITS == 4'h7)
    else $error("seven-bit width wrong");
  uart_clk_a: assert property (@(posedge CLK) disable iff (!RST_B)
    is_uart($past(sm)) |-> XFER_CLK_SEL == $past(mode0_r[M0_SC_HI:M0_SC_LO]))
    else $error("UART clock select wrong");
  sync_clk_a: assert property (@(posedge CLK) disable iff (!RST_B)
    $past(RST_B) && $past(sm) == FM_SYNC |-> XFER_CLK_SEL == ($past(CR_CLK_PIN_SEL) ? CK_PIN : CK_BRG))
    else $error("sync clock select wrong");
  ninth_tx_a: assert property (@(posedge CLK) disable iff (!RST_B)
    TX_BIT8 |-> $past(sm) == FM_UART9 && $past(mode0_r[M0_TX9]))
    else $error("ninth bit outside nine-bit mode");
  cts_gate_a: assert property (@(posedge CLK) disable iff (!RST_B)
    $past(is_uart(sm) && mode0_r[M0_HSK] && !cts_r) |-> !TX_ALLOW)
    else $error("transmit allowed without CTS");
  wake_filter_a: assert property (@(posedge CLK) disable iff (!RST_B)
    RX_DONE && sm == FM_UART9 && mode0_r[M0_WU] && !RX_NINTH |=> !RX_IRQ_PULSE)
    else $error("wake-up filter let character through");
  idle_halt_a: assert property (@(posedge CLK) disable iff (!RST_B)
    CHIP_IDLE && !mode1_r[M1_IDLE] |=> !CH_RUN && !TX_ALLOW && !RX_ALLOW)
    else $error("channel ran in idle");
  txe_block_a: assert property (@(posedge CLK) disable iff (!RST_B)
    !mode1_r[M1_TXE] |=> !TX_ALLOW)
    else $error("transmit without enable");
  sync_dir_a: assert property (@(posedge CLK) disable iff (!RST_B)
    sm == FM_SYNC && dpx == DPX_RX |=> !TX_ALLOW)
    else $error("sync transmit in receive-only duplex");
  sync_rx_dir_a: assert property (@(posedge CLK) disable iff (!RST_B)
    sm == FM_SYNC && dpx == DPX_TX |=> !RX_ALLOW)
    else $error("sync receive in transmit-only duplex");
  fifo_sync_a: assert property (@(posedge CLK) disable iff (!RST_B)
    sm == FM_SYNC && !FIFO_EN |=> FIFO_ARR == DPX_NONE)
    else $error("FIFO arrangement set without FIFO in sync mode");
  read_upper_a: assert property (@(posedge CLK) disable iff (!RST_B)
    RD |=> RDATA[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  gap_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
    TX_DONE && gap_on && mode1_r[M1_GAP_HI:M1_GAP_LO] != 3'h0 && !swrst_fire ##1 gap_on |-> gap_busy)
    else $error("gap not started");
  gap_off_a: assert property (@(posedge CLK) disable iff (!RST_B)
    !gap_on |=> !gap_busy)
    else $error("gap outside sync clock output mode");
  bit0_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
    !mode1_r[M1_UNUSED])
    else $error("unused bit set");
endmodule
`default_nettype wire

//--- core/scm_pkg.sv
// Package: register map, field layout and encodings of the serial mode control block
package scm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SCM_MODE0_ADDR = 8'h00;
  localparam logic [7:0] SCM_MODE1_ADDR = 8'h04;
  localparam logic [7:0] SCM_SWRST_ADDR = 8'h08;
  localparam logic [7:0] SCM_STAT_ADDR = 8'h0C;
  localparam logic [7:0] SCM_IRQ_STAT_ADDR = 8'h10;
  localparam logic [7:0] SCM_IRQ_EN_ADDR = 8'h14;
  localparam logic [7:0] SCM_IRQ_CLR_ADDR = 8'h18;

  localparam logic [7:0] SCM_MODE0_RST = 8'h00;
  localparam logic [7:0] SCM_MODE1_RST = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int M0_TX9 = 7;
  localparam int M0_HSK = 6;
  localparam int M0_RXE = 5;
  localparam int M0_WU = 4;
  localparam int M0_SM_HI = 3;
  localparam int M0_SM_LO = 2;
  localparam int M0_SC_HI = 1;
  localparam int M0_SC_LO = 0;
  localparam int M1_IDLE = 7;
  localparam int M1_DPX_HI = 6;
  localparam int M1_DPX_LO = 5;
  localparam int M1_TXE = 4;
  localparam int M1_GAP_HI = 3;
  localparam int M1_GAP_LO = 1;
  localparam int M1_UNUSED = 0;

  // Software reset key pair on the low two bits
  localparam logic [1:0] SWRST_ARM = 2'b10;
  localparam logic [1:0] SWRST_FIRE = 2'b01;

  // Interrupt status bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_SWRST = 1;
  localparam int IRQ_W = 2;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FM_SYNC = 2'b00, FM_UART7 = 2'b01, FM_UART8 = 2'b10, FM_UART9 = 2'b11
  } scm_frame_type;

  typedef enum logic [1:0] {
    CK_TIMER = 2'b00, CK_BRG = 2'b01, CK_SYS = 2'b10, CK_PIN = 2'b11
  } scm_clk_type;

  typedef enum logic [1:0] {
    DPX_NONE = 2'b00, DPX_RX = 2'b01, DPX_TX = 2'b10, DPX_FULL = 2'b11
  } scm_dpx_type;

  localparam logic [6:0] GAP_MAX_CYC = 7'h40;

endpackage

//--- core/scm_gap_timer.sv
// Idle gap counter between back-to-back synchronous transmissions
`timescale 1ns/1ps
`default_nettype none
module scm_gap_timer (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic start,
  input wire logic [2:0] code,
  input wire logic sclk_tick,
  input wire logic flush,
  output logic busy
);
  import scm_pkg::*;

  logic [6:0] count_r;

  // Code n above zero waits 2**(n-1) serial clock periods
  always_ff @(posedge CLK) begin
    if (!RST_B || flush) begin
      count_r <= 7'h00;
    end else if (start && code != 3'h0) begin
      count_r <= 7'(7'h01 << (code - 3'h1));
    end else if (sclk_tick && count_r != 7'h00) begin
      count_r <= count_r - 7'h01;
    end
  end

  assign busy = (count_r != 7'h00);

  gap_bound_a: assert property (@(posedge CLK) disable iff (!RST_B) count_r <= GAP_MAX_CYC)
    else $error("gap count above maximum");
endmodule
`default_nettype wire

//--- sim/scm_peer_model.sv
// Far-side serial peer: handshake pin, serial clock ticks and character events
`timescale 1ns/1ps
`default_nettype none
module scm_peer_model (
  input wire logic clk,
  output logic cts_pin,
  output logic sclk_tick,
  output logic rx_done,
  output logic rx_ninth,
  output logic tx_done
);
  logic [1:0] div_r = 2'h0;

  initial begin
    cts_pin = 1'b0;
    rx_done = 1'b0;
    rx_ninth = 1'b1;
    tx_done = 1'b0;
  end

  // Serial clock runs free at a quarter of the system clock
  always_ff @(posedge clk) begin
    div_r <= div_r + 2'h1;
  end
  assign sclk_tick = (div_r == 2'h3);

  task automatic set_cts(input logic v);
    @(posedge clk);
    cts_pin <= v;
  endtask

  // Ninth bit means nothing outside the done pulse, so it shows the inverse there
  task automatic send_rx(input logic ninth);
    @(posedge clk);
    rx_done <= 1'b1;
    rx_ninth <= ninth;
    @(posedge clk);
    rx_done <= 1'b0;
    rx_ninth <= ~ninth;
  endtask

  task automatic end_tx();
    @(posedge clk);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- sim/scm_mode_ctrl_test.sv
// Self-checking testbench of the serial mode control block
`timescale 1ns/1ps
`default_nettype none
module scm_mode_ctrl_test;
  import scm_pkg::*;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic CHIP_IDLE = 1'b0;
  logic CR_CLK_PIN_SEL = 1'b1;
  logic SCLK_OUT_MODE = 1'b0;
  logic DBL_BUF_EN = 1'b0;
  logic FIFO_EN = 1'b0;
  logic [31:0] RDATA;
  logic [1:0] FRAME_MODE, XFER_CLK_SEL, FIFO_ARR;
  logic [3:0] DATA_BITS;
  logic TX_BIT8, TX_ALLOW, RX_ALLOW, RX_IRQ_PULSE, CH_RUN, ENGINE_RST, IRQ;
  logic CTS_PIN, SCLK_TICK, TX_DONE, RX_DONE, RX_NINTH;
  int n_mismatch = 0;
  int samples_checked = 0;
  int rx_pulses = 0;
  int eng_pulses = 0;
  int n, p;

  always #5 CLK = ~CLK;

  always_ff @(posedge CLK) begin
    rx_pulses <= rx_pulses + (RX_IRQ_PULSE === 1'b1);
    eng_pulses <= eng_pulses + (ENGINE_RST === 1'b1);
  end

  scm_mode_ctrl i_scm_mode_ctrl (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CTS_PIN(CTS_PIN), .CHIP_IDLE(CHIP_IDLE), .CR_CLK_PIN_SEL(CR_CLK_PIN_SEL),
    .SCLK_OUT_MODE(SCLK_OUT_MODE), .DBL_BUF_EN(DBL_BUF_EN), .FIFO_EN(FIFO_EN), .SCLK_TICK(SCLK_TICK),
    .TX_DONE(TX_DONE), .RX_DONE(RX_DONE), .RX_NINTH(RX_NINTH), .FRAME_MODE(FRAME_MODE),
    .DATA_BITS(DATA_BITS), .XFER_CLK_SEL(XFER_CLK_SEL), .TX_BIT8(TX_BIT8), .TX_ALLOW(TX_ALLOW),
    .RX_ALLOW(RX_ALLOW), .RX_IRQ_PULSE(RX_IRQ_PULSE), .CH_RUN(CH_RUN), .FIFO_ARR(FIFO_ARR),
    .ENGINE_RST(ENGINE_RST), .IRQ(IRQ));

  scm_peer_model i_scm_peer_model (.clk(CLK), .cts_pin(CTS_PIN), .sclk_tick(SCLK_TICK),
    .rx_done(RX_DONE), .rx_ninth(RX_NINTH), .tx_done(TX_DONE));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, exp);
  endtask

  // Outputs are registered behind the mode registers, so give them time to land
  task automatic settle();
    repeat (3) @(posedge CLK);
    #1;
  endtask

  task automatic wait_tx(input logic v, input int lim, output int cnt);
    cnt = 0;
    // Step off the launching edge before the first look
    #1;
    while (TX_ALLOW !== v) begin
      if (cnt == lim) begin
        chk(TX_ALLOW, v);
        tally_and_finish();
      end
      @(posedge CLK);
      #1 cnt++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    rd_chk(SCM_MODE0_ADDR, 32'h0);
    rd_chk(SCM_MODE1_ADDR, 32'h0);
    chk(DATA_BITS, 32'h8);
    wr(SCM_MODE1_ADDR, 32'hFFFF_FFFF);
    rd_chk(SCM_MODE1_ADDR, 32'hFE);
    wr(SCM_MODE1_ADDR, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(SCM_MODE0_ADDR, {24'h0, 4'h8, m[1:0], 2'h2});
      settle();
      chk(FRAME_MODE, m);
      chk(DATA_BITS, m == 1 ? 7 : m == 3 ? 9 : 8);
      chk(XFER_CLK_SEL, m == 0 ? 3 : 2);
      chk(TX_BIT8, m == 3);
    end
    for (int s = 0; s < 4; s++) begin
      wr(SCM_MODE0_ADDR, 32'h08 + s);
      settle();
      chk(XFER_CLK_SEL, s);
    end
    @(posedge CLK) CR_CLK_PIN_SEL <= 1'b0;
    wr(SCM_MODE0_ADDR, 32'h03);
    settle();
    chk(XFER_CLK_SEL, 1);
    wr(SCM_MODE0_ADDR, 32'h08);
    for (int d = 0; d < 4; d++) begin
      wr(SCM_MODE1_ADDR, d << 5);
      settle();
      chk(FIFO_ARR, d);
    end
    wr(SCM_MODE0_ADDR, 32'h00);
    settle();
    chk(FIFO_ARR, 0);
    @(posedge CLK) FIFO_EN <= 1'b1;
    settle();
    chk(FIFO_ARR, 3);
    wr(SCM_MODE1_ADDR, 32'h30);
    settle();
    chk(TX_ALLOW, 0);
    wr(SCM_MODE1_ADDR, 32'h50);
    settle();
    chk(TX_ALLOW, 1);
    wr(SCM_MODE1_ADDR, 32'h0);
    wr(SCM_MODE0_ADDR, 32'h48);
    wr(SCM_MODE1_ADDR, 32'h10);
    settle();
    chk(TX_ALLOW, 0);
    i_scm_peer_model.set_cts(1'b1);
    wait_tx(1'b1, 8, n);
    wr(SCM_MODE0_ADDR, 32'h08);
    i_scm_peer_model.set_cts(1'b0);
    settle();
    settle();
    chk(TX_ALLOW, 1);
    @(posedge CLK) CHIP_IDLE <= 1'b1;
    settle();
    chk(CH_RUN, 0);
    chk(TX_ALLOW, 0);
    wr(SCM_MODE1_ADDR, 32'h90);
    settle();
    chk(CH_RUN, 1);
    @(posedge CLK) CHIP_IDLE <= 1'b0;
    wr(SCM_MODE1_ADDR, 32'h0);
    settle();
    chk(TX_ALLOW, 0);
    // Gap of four serial clocks: sync, clock output, double buffered
    wr(SCM_MODE0_ADDR, 32'h00);
    @(posedge CLK) SCLK_OUT_MODE <= 1'b1;
    @(posedge CLK) DBL_BUF_EN <= 1'b1;
    wr(SCM_MODE1_ADDR, 32'h66);
    wr(SCM_MODE1_ADDR, 32'h76);
    settle();
    chk(TX_ALLOW, 1);
    i_scm_peer_model.end_tx();
    wait_tx(1'b0, 4, n);
    wait_tx(1'b1, 40, n);
    chk(n >= 12 && n <= 18, 1);
    @(posedge CLK) DBL_BUF_EN <= 1'b0;
    i_scm_peer_model.end_tx();
    repeat (6) begin
      @(posedge CLK);
      #1 chk(TX_ALLOW, 1);
    end
    // Wake filter and interrupt path
    wr(SCM_MODE1_ADDR, 32'h0);
    wr(SCM_MODE0_ADDR, 32'h1C);
    wr(SCM_MODE0_ADDR, 32'h3C);
    wr(SCM_IRQ_EN_ADDR, 32'h1);
    p = rx_pulses;
    i_scm_peer_model.send_rx(1'b0);
    settle();
    chk(rx_pulses - p, 0);
    chk(IRQ, 0);
    i_scm_peer_model.send_rx(1'b1);
    settle();
    chk(rx_pulses - p, 1);
    chk(IRQ, 1);
    chk(RX_ALLOW, 1);
    wr(SCM_IRQ_EN_ADDR, 32'h0);
    settle();
    chk(IRQ, 0);
    rd_chk(SCM_IRQ_STAT_ADDR, 32'h1);
    wr(SCM_IRQ_CLR_ADDR, 32'h1);
    wr(SCM_IRQ_EN_ADDR, 32'h1);
    settle();
    chk(IRQ, 0);
    rd_chk(SCM_IRQ_STAT_ADDR, 32'h0);
    wr(SCM_MODE0_ADDR, 32'h38);
    i_scm_peer_model.send_rx(1'b0);
    settle();
    chk(rx_pulses - p, 2);
    // Software reset: a stray key write disarms it
    wr(SCM_MODE1_ADDR, 32'h10);
    wr(SCM_SWRST_ADDR, 32'h2);
    wr(SCM_SWRST_ADDR, 32'h3);
    wr(SCM_SWRST_ADDR, 32'h1);
    settle();
    rd_chk(SCM_MODE0_ADDR, 32'h38);
    p = eng_pulses;
    wr(SCM_SWRST_ADDR, 32'h2);
    wr(SCM_SWRST_ADDR, 32'h1);
    settle();
    rd_chk(SCM_MODE0_ADDR, 32'h18);
    rd_chk(SCM_MODE1_ADDR, 32'h00);
    chk(eng_pulses - p, 1);
    chk(RX_ALLOW, 0);
    rd_chk(8'h1C, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
